// File: rtl/row_flash_host_pkg.sv
// constants, register map and state types of the security row / ddr read host
package row_flash_host_pkg;
  // flash opcodes
  localparam logic [7:0] OPC_ROW_ERASE     = 8'h64;
  localparam logic [7:0] OPC_ROW_PROGRAM   = 8'h62;
  localparam logic [7:0] OPC_ROW_READ      = 8'h68;
  localparam logic [7:0] OPC_SINGLE_DDR    = 8'h0d;
  localparam logic [7:0] OPC_DUAL_DDR      = 8'hbd;
  localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_STATUS_READ   = 8'h05;
  // dual ddr mode bytes
  localparam logic [7:0] MODE_CONT         = 8'ha0;
  localparam logic [7:0] MODE_EXIT         = 8'hff;
  localparam logic [3:0] MODE_CLOCKS       = 4'h2;
  localparam logic [5:0] MODE_NIBBLE_BEATS = 6'h02;
  localparam logic [5:0] MODE_BYTE_BEATS   = 6'h04;
  // row addressing
  localparam logic [7:0] ROW_ADDR_HI       = 8'h00;
  localparam logic [8:0] ROW_BYTES         = 9'h100;
  localparam int         ROW_SEL_LSB       = 8;
  localparam int         WIP_BIT           = 0;
  // beats per phase for 1, 2 and 4 lines
  localparam logic [5:0] OPC_BEATS_1       = 6'h08;
  localparam logic [5:0] OPC_BEATS_4       = 6'h02;
  localparam logic [5:0] ADR_BEATS_1       = 6'h18;
  localparam logic [5:0] ADR_BEATS_2       = 6'h0c;
  localparam logic [5:0] ADR_BEATS_4       = 6'h06;
  localparam logic [3:0] BYTE_BITS         = 4'h8;
  // register byte offsets
  localparam logic [7:0] REG_CMD           = 8'h00;
  localparam logic [7:0] REG_ADDR          = 8'h04;
  localparam logic [7:0] REG_LEN           = 8'h08;
  localparam logic [7:0] REG_CFG           = 8'h0c;
  localparam logic [7:0] REG_TXDATA        = 8'h10;
  localparam logic [7:0] REG_RXDATA        = 8'h14;
  localparam logic [7:0] REG_STATUS        = 8'h18;
  // cfg fields and reset values
  localparam int         CFG_ROW_DUMMY_LSB  = 0;
  localparam int         CFG_DUAL_DUMMY_LSB = 4;
  localparam int         CFG_QUAD_DUMMY_LSB = 8;
  localparam int         CFG_CONT_BIT       = 12;
  localparam logic [3:0] DUMMY_ROW_RST      = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_RST     = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_RST     = 4'h6;
  // status fields
  localparam int         ST_BUSY_BIT       = 0;
  localparam int         ST_TXFULL_BIT     = 1;
  localparam int         ST_RXFULL_BIT     = 2;
  localparam int         ST_CONT_BIT       = 3;
  localparam int         ST_ERR_BIT        = 4;
  localparam int         ST_FLASH_LSB      = 8;
  // operations started through the command register
  typedef enum logic [2:0] {
    OP_ROW_ERASE   = 3'h0,
    OP_ROW_PROGRAM = 3'h1,
    OP_ROW_READ    = 3'h2,
    OP_SINGLE_DDR  = 3'h3,
    OP_DUAL_DDR    = 3'h4,
    OP_QUAD_DDR    = 3'h5,
    OP_STATUS      = 3'h6,
    OP_NONE        = 3'h7
  } op_kind_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN  = 3'b010,
    S_GAP  = 3'b100
  } state_e;
  typedef enum logic [3:0] {
    ST_PRE  = 4'b0001,
    ST_WRITE_ENABLE_CMD = 4'b0010,
    ST_MAIN = 4'b0100,
    ST_POST = 4'b1000
  } step_e;
  typedef enum logic [5:0] {
    P_LOAD = 6'b000001,
    P_OPC  = 6'b000010,
    P_ADR  = 6'b000100,
    P_DUM  = 6'b001000,
    P_DAT  = 6'b010000,
    P_END  = 6'b100000
  } phase_e;
endpackage

// File: rtl/line_sync.sv
// two flip-flop synchroniser for the flash data lines
module line_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// File: rtl/row_flash_host.sv
// apb-controlled host for security rows and ddr fast reads of a serial flash
// Overview of operation
// - erase is 64h plus three address bytes, select low, starts on rise
// - write enable precedes an erase; device clears the latch afterwards
// - program is 62h, row address, 1-256 bytes; starts on select rise
// - row read is 68h, address, dummy clocks default 8, then data
// - read address increments; host starts each row read at the byte offset in addr_q[7:0]
// - single ddr 0Dh: opcode 1 bit per clock, address and data 2
// - four-line 0Dh: 2 opcode clocks, address 8 bits per clock, 6 dummy
// - dual ddr BDh: address and data 4 bits per clock, 4 dummy
// - mode upper nibble A enters continuous mode, anything else leaves
// - host keeps select low for the whole erase; read may end anytime
// - host gives enough dummy; lower mode nibble released when they match
module row_flash_host
  import row_flash_host_pkg::*;
#(
  parameter int HALF_DIV = 4
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output logic             cs_n,
  output logic             sck,
  input  wire logic [3:0]  dq_in,
  output logic      [3:0]  dq_out,
  output logic      [3:0]  dq_oe
);
  if (HALF_DIV < 4 || HALF_DIV > 127)
  begin : g_bad_div
    $error("HALF_DIV must lie between 4 and 127");
  end

  localparam logic [7:0] HALF_MID  = 8'(HALF_DIV / 2);
  localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);
  localparam logic [7:0] GAP_LAST  = 8'(2 * HALF_DIV - 1);

  state_e      state_q, state_d;
  step_e       step_q, step_d;
  phase_e      ph_q, ph_d, nxt;
  op_kind_e    op_q, op_d;
  logic [7:0]  half_q, half_d;
  logic        sck_q, sck_d, cs_n_q, cs_n_d;
  logic [3:0]  dq_out_q, dq_out_d, dq_oe_q, dq_oe_d;
  logic [31:0] sr_q, sr_d, src;
  logic [5:0]  beats_q, beats_d;
  logic [3:0]  bits_q, bits_d;
  logic [8:0]  bytes_q, bytes_d, len_q, len_d, len_eff;
  logic        armed_q, armed_d;
  logic [7:0]  rdat_q, rdat_d, rx_q, rx_d, tx_q, tx_d, stat_q, stat_d, in_byte;
  logic        rx_full_q, rx_full_d, tx_full_q, tx_full_d, rx_set;
  logic [23:0] addr_q, addr_d;
  logic [12:0] cfg_q, cfg_d;
  logic        cont_q, cont_d, err_q, err_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [3:0]  dq_s;
  // frame description
  logic [7:0]  f_op;
  logic [2:0]  f_opl, f_lines, nl;
  logic        f_ddr, f_addr, f_rd, f_wr, f_mode, ddr, poll, skip_opc, needs_wel, row_op;
  logic [3:0]  f_dum;
  logic [5:0]  dum_beats, mode_idx, adr_beats;
  logic [23:0] f_adr, row_addr;
  logic        launch, sample, stall, enter, acc, setup, mapped, in_progress_flag, start_frame;

  line_sync #(.WIDTH(4)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (dq_in),
    .q     (dq_s)
  );

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign cs_n    = cs_n_q;
  assign sck     = sck_q;
  assign dq_out  = dq_out_q;
  assign dq_oe   = dq_oe_q;

  // frame shape of the current step
  always_comb
  begin
    row_addr  = {ROW_ADDR_HI, 2'b00, addr_q[ROW_SEL_LSB+1:ROW_SEL_LSB], 4'h0, addr_q[7:0]};
    row_op    = (op_q == OP_ROW_ERASE) || (op_q == OP_ROW_PROGRAM) || (op_q == OP_ROW_READ);
    needs_wel = (op_q == OP_ROW_ERASE) || (op_q == OP_ROW_PROGRAM);
    poll      = (step_q == ST_PRE) || (step_q == ST_POST);
    skip_opc  = (step_q == ST_MAIN) && (op_q == OP_DUAL_DDR) && cont_q;
    f_op = OPC_STATUS_READ;
    f_opl = 3'd1;
    f_lines = 3'd1;
    f_ddr = 1'b0;
    f_addr = 1'b0;
    f_dum = 4'h0;
    f_rd = 1'b1;
    f_wr = 1'b0;
    f_mode = 1'b0;
    f_adr = row_addr;
    if (step_q == ST_WRITE_ENABLE_CMD)
    begin
      f_op = OPC_WRITE_ENABLE;
      f_rd = 1'b0;
    end
    else if (step_q == ST_MAIN)
    begin
      case (op_q)
        OP_ROW_ERASE:   begin f_op = OPC_ROW_ERASE; f_addr = 1'b1; f_rd = 1'b0; end
        OP_ROW_PROGRAM: begin f_op = OPC_ROW_PROGRAM; f_addr = 1'b1; f_rd = 1'b0; f_wr = 1'b1; end
        OP_ROW_READ:    begin f_op = OPC_ROW_READ; f_addr = 1'b1;
                              f_dum = cfg_q[CFG_ROW_DUMMY_LSB+:4]; end
        OP_SINGLE_DDR:  begin f_op = OPC_SINGLE_DDR; f_addr = 1'b1; f_ddr = 1'b1;
                              f_dum = cfg_q[CFG_ROW_DUMMY_LSB+:4]; f_adr = addr_q; end
        OP_DUAL_DDR:    begin f_op = OPC_DUAL_DDR; f_addr = 1'b1; f_ddr = 1'b1; f_lines = 3'd2;
                              f_dum = cfg_q[CFG_DUAL_DUMMY_LSB+:4]; f_adr = addr_q; f_mode = 1'b1; end
        OP_QUAD_DDR:    begin f_op = OPC_SINGLE_DDR; f_opl = 3'd4; f_addr = 1'b1; f_ddr = 1'b1;
                              f_lines = 3'd4; f_dum = cfg_q[CFG_QUAD_DUMMY_LSB+:4];
                              f_adr = addr_q; end
        default:        begin f_op = OPC_STATUS_READ; end
      endcase
    end
    nl        = (ph_q == P_OPC) ? f_opl : f_lines;
    adr_beats = (f_lines == 3'd4) ? ADR_BEATS_4 : ((f_lines == 3'd2) ? ADR_BEATS_2 : ADR_BEATS_1);
    // the high half that closes the last opcode clock carries no address bit
    ddr       = (ph_q != P_OPC) && f_ddr
             && !(ph_q == P_ADR && sck_q && beats_q == adr_beats);
    dum_beats = f_ddr ? {1'b0, f_dum, 1'b0} : {2'b00, f_dum};
    mode_idx  = dum_beats - beats_q;
    len_eff   = (len_q == 9'h000) ? 9'h001 : len_q;
    if (row_op && len_eff > ROW_BYTES)
      len_eff = ROW_BYTES;
    case (ph_q)
      P_LOAD:  nxt = skip_opc ? P_ADR : P_OPC;
      P_OPC:   nxt = f_addr ? P_ADR : ((f_rd || f_wr) ? P_DAT : P_END);
      P_ADR:   nxt = (f_dum != 4'h0) ? P_DUM : ((f_rd || f_wr) ? P_DAT : P_END);
      P_DUM:   nxt = P_DAT;
      default: nxt = P_END;
    endcase
  end

  // engine and register file next values
  always_comb
  begin
    state_d = state_q; step_d = step_q; ph_d = ph_q; op_d = op_q; half_d = half_q;
    sck_d = sck_q; cs_n_d = cs_n_q; dq_out_d = dq_out_q; dq_oe_d = dq_oe_q;
    sr_d = sr_q; beats_d = beats_q; bits_d = bits_q; bytes_d = bytes_q; armed_d = armed_q;
    rdat_d = rdat_q; rx_d = rx_q; tx_d = tx_q; stat_d = stat_q; rx_full_d = rx_full_q;
    tx_full_d = tx_full_q; addr_d = addr_q; len_d = len_q; cfg_d = cfg_q; cont_d = cont_q;
    err_d = err_q; prdata_d = 32'h0; rx_set = 1'b0; enter = 1'b0; start_frame = 1'b0;
    src = sr_q; in_byte = rdat_q; launch = 1'b0; sample = 1'b0; stall = 1'b0;
    in_progress_flag = stat_q[WIP_BIT];
    case (state_q)
      S_RUN:
      begin
        if (ph_q == P_LOAD)
        begin
          enter = 1'b1;
          half_d = 8'h00;
          bytes_d = poll ? 9'h001 : len_eff;
          if (skip_opc || f_mode)
            cont_d = cfg_q[CFG_CONT_BIT] && f_mode;
        end
        else
        begin
          launch = (half_q == HALF_MID) && (ddr || !sck_q);
          sample = (half_q == HALF_LAST) && (ddr || !sck_q) && (ph_q == P_DAT) && f_rd && armed_q;
          stall  = (launch && ph_q == P_DAT && f_wr && bits_q == 4'h0 && !tx_full_q)
                 || (sample && bits_q == 4'h0 && rx_full_q && !poll);
          if (!stall)
          begin
            half_d = half_q + 8'h01;
            if (launch && ph_q == P_DAT && f_rd)
            begin
              armed_d = 1'b1;
              dq_oe_d = 4'h0;
            end
            else if (launch && ph_q != P_END)
            begin
              if (ph_q == P_DAT && bits_q == 4'h0)
              begin
                src = {tx_q, 24'h0};
                tx_full_d = 1'b0;
              end
              case (nl)
                3'd4:    begin dq_out_d = src[31:28]; dq_oe_d = 4'hf; end
                3'd2:    begin dq_out_d = {2'b00, src[31:30]}; dq_oe_d = 4'h3; end
                default: begin dq_out_d = {3'b000, src[31]}; dq_oe_d = 4'h1; end
              endcase
              if (ph_q == P_DUM)
              begin
                if (!f_mode || mode_idx >= MODE_BYTE_BEATS
                    || (mode_idx >= MODE_NIBBLE_BEATS && f_dum == MODE_CLOCKS))
                  dq_oe_d = 4'h0;
              end
              sr_d = src << nl;
              if (ph_q == P_DAT)
              begin
                bits_d = bits_q + {1'b0, nl};
                if (bits_d == BYTE_BITS)
                begin
                  bits_d = 4'h0;
                  bytes_d = bytes_q - 9'h001;
                  if (bytes_q == 9'h001)
                    ph_d = P_END;
                end
              end
              else
              begin
                beats_d = beats_q - 6'h01;
                if (beats_q == 6'h01)
                  enter = 1'b1;
              end
            end
            else if (launch)
              dq_oe_d = 4'h0;
            if (sample)
            begin
              case (nl)
                3'd4:    in_byte = {rdat_q[3:0], dq_s};
                3'd2:    in_byte = {rdat_q[5:0], dq_s[1:0]};
                default: in_byte = {rdat_q[6:0], dq_s[1]};
              endcase
              rdat_d = in_byte;
              bits_d = bits_q + {1'b0, nl};
              if (bits_d == BYTE_BITS)
              begin
                bits_d = 4'h0;
                bytes_d = bytes_q - 9'h001;
                if (poll)
                  stat_d = in_byte;
                else
                begin
                  rx_d = in_byte;
                  rx_set = 1'b1;
                end
                if (bytes_q == 9'h001)
                  ph_d = P_END;
              end
            end
          end
        end
        if (enter)
        begin
          ph_d = nxt;
          case (nxt)
            P_OPC:
            begin
              sr_d = {f_op, 24'h0};
              beats_d = (f_opl == 3'd4) ? OPC_BEATS_4 : OPC_BEATS_1;
            end
            P_ADR:
            begin
              sr_d = {f_adr, 8'h00};
              beats_d = adr_beats;
            end
            P_DUM:
            begin
              sr_d = {(cfg_q[CFG_CONT_BIT] ? MODE_CONT : MODE_EXIT), 24'h0};
              beats_d = dum_beats;
            end
            default:
            begin
              bits_d = 4'h0;
              armed_d = 1'b0;
            end
          endcase
        end
        if (!stall && ph_q != P_LOAD && half_q == HALF_LAST)
        begin
          half_d = 8'h00;
          if (ph_d == P_END && sck_q)
          begin
            cs_n_d = 1'b1;
            sck_d = 1'b0;
            dq_oe_d = 4'h0;
            state_d = S_GAP;
          end
          else
            sck_d = !sck_q;
        end
      end
      S_GAP:
      begin
        half_d = half_q + 8'h01;
        if (half_q == GAP_LAST)
        begin
          start_frame = 1'b1;
          case (step_q)
            ST_PRE:  if (!in_progress_flag) step_d = needs_wel ? ST_WRITE_ENABLE_CMD : ST_MAIN;
            ST_WRITE_ENABLE_CMD: step_d = ST_MAIN;
            ST_MAIN:
            begin
              if (needs_wel)
                step_d = ST_POST;
              else
                start_frame = 1'b0;
            end
            default: start_frame = in_progress_flag;
          endcase
          if (!start_frame)
            state_d = S_IDLE;
        end
      end
      default: ;
    endcase
    // apb slave, zero wait states
    acc = psel && penable && pready_q;
    setup = psel && !penable;
    mapped = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_LEN) || (paddr == REG_CFG)
           || (paddr == REG_TXDATA) || (paddr == REG_RXDATA) || (paddr == REG_STATUS);
    pready_d = setup;
    pslverr_d = setup && !mapped;
    if (setup && !pwrite)
    begin
      case (paddr)
        REG_CMD:    prdata_d = {29'h0, op_q};
        REG_ADDR:   prdata_d = {8'h00, addr_q};
        REG_LEN:    prdata_d = {23'h0, len_q};
        REG_CFG:    prdata_d = {19'h0, cfg_q};
        REG_RXDATA: prdata_d = {24'h0, rx_q};
        REG_STATUS: prdata_d = {16'h0, stat_q, 3'b000, err_q, cont_q, rx_full_q, tx_full_q,
                                state_q != S_IDLE};
        default:    prdata_d = 32'h0;
      endcase
    end
    if (acc && !pwrite && paddr == REG_RXDATA)
      rx_full_d = 1'b0;
    if (acc && pwrite)
    begin
      case (paddr)
        REG_ADDR:   addr_d = pwdata[23:0];
        REG_LEN:    len_d = pwdata[8:0];
        REG_CFG:    cfg_d = pwdata[12:0];
        REG_TXDATA: begin tx_d = pwdata[7:0]; tx_full_d = 1'b1; end
        REG_STATUS: if (pwdata[ST_ERR_BIT]) err_d = 1'b0;
        REG_CMD:
        begin
          if (state_q != S_IDLE || op_kind_e'(pwdata[2:0]) == OP_NONE
              || (cont_q && op_kind_e'(pwdata[2:0]) != OP_DUAL_DDR))
            err_d = 1'b1;
          else
          begin
            op_d = op_kind_e'(pwdata[2:0]);
            start_frame = 1'b1;
            step_d = (op_d == OP_QUAD_DDR || op_d == OP_STATUS || cont_q) ? ST_MAIN : ST_PRE;
          end
        end
        default: ;
      endcase
    end
    if (rx_set)
      rx_full_d = 1'b1;
    if (start_frame)
    begin
      state_d = S_RUN;
      cs_n_d = 1'b0;
      ph_d = P_LOAD;
      half_d = 8'h00;
      sck_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_IDLE; step_q <= ST_MAIN; ph_q <= P_END; op_q <= OP_STATUS;
      half_q <= 8'h00; sck_q <= 1'b0; cs_n_q <= 1'b1; dq_out_q <= 4'h0; dq_oe_q <= 4'h0;
      sr_q <= 32'h0; beats_q <= 6'h00; bits_q <= 4'h0; bytes_q <= 9'h000; armed_q <= 1'b0;
      rdat_q <= 8'h00; rx_q <= 8'h00; tx_q <= 8'h00; stat_q <= 8'h00;
      rx_full_q <= 1'b0; tx_full_q <= 1'b0; addr_q <= 24'h0; len_q <= 9'h001;
      cfg_q <= {1'b0, DUMMY_QUAD_RST, DUMMY_DUAL_RST, DUMMY_ROW_RST};
      cont_q <= 1'b0; err_q <= 1'b0; prdata_q <= 32'h0; pready_q <= 1'b0; pslverr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d; step_q <= step_d; ph_q <= ph_d; op_q <= op_d;
      half_q <= half_d; sck_q <= sck_d; cs_n_q <= cs_n_d; dq_out_q <= dq_out_d; dq_oe_q <= dq_oe_d;
      sr_q <= sr_d; beats_q <= beats_d; bits_q <= bits_d; bytes_q <= bytes_d; armed_q <= armed_d;
      rdat_q <= rdat_d; rx_q <= rx_d; tx_q <= tx_d; stat_q <= stat_d;
      rx_full_q <= rx_full_d; tx_full_q <= tx_full_d; addr_q <= addr_d; len_q <= len_d;
      cfg_q <= cfg_d; cont_q <= cont_d; err_q <= err_d;
      prdata_q <= prdata_d; pready_q <= pready_d; pslverr_q <= pslverr_d;
    end
  end
endmodule

// File: verif/row_flash_host_checker.sv
// pin-level checks of the row flash host
module row_flash_host_checker
  import row_flash_host_pkg::*;
#(
  parameter int HALF_DIV = 4
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // flash pins
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic [3:0]  dq_out,
  input wire logic [3:0]  dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hi_q, hi_d, gap_q, gap_d;
  always_comb
  begin
    hi_d  = sck ? hi_q + 8'h1 : 8'h0;
    gap_d = !cs_n ? 8'h0 : (gap_q == 8'hff ? gap_q : gap_q + 8'h1);
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      hi_q  <= 8'h0;
      gap_q <= 8'hff;
    end
    else
    begin
      hi_q  <= hi_d;
      gap_q <= gap_d;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  chk_zero_wait: assert property (s_setup |=> s_access)
    else $error("no ready in first access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  chk_err_unmapped: assert property (pready && paddr > REG_STATUS |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready && paddr <= REG_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_high_half: assert property ($fell(sck) |-> hi_q == 8'(HALF_DIV))
    else $error("wrong sck high half");
  chk_frame_gap: assert property ($fell(cs_n) |-> gap_q >= 8'(2 * HALF_DIV))
    else $error("select gap too short");
  chk_end_together: assert property ($rose(cs_n) |-> $fell(sck))
    else $error("select rose outside high half end");
  chk_idle_pins: assert property (cs_n |-> !sck && dq_oe == 4'h0)
    else $error("pins active while deselected");
  chk_no_edge_launch: assert property (!cs_n && $changed(sck) |-> $stable(dq_out) && $stable(dq_oe))
    else $error("data changed on an sck edge");
endmodule

bind row_flash_host row_flash_host_checker #(.HALF_DIV(HALF_DIV)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sck(sck),
  .dq_out(dq_out), .dq_oe(dq_oe));

// File: verif/flash_row_model.sv
// behavioural flash with security rows and single-line ddr read
module flash_row_model #(
  parameter logic [3:0] LOCK    = 4'h8,
  parameter int         BUSY_NS = 5000
) (
  // flash pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] dq,
  output logic      [3:0] dev_dq,
  output logic      [3:0] dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:1023];
  logic [7:0]  pbuf [0:255];
  logic        pmask [0:255];
  logic [31:0] sr;
  logic [23:0] adr, a;
  logic [7:0]  opc, ob, off;
  logic        in_progress_flag = 1'b0, write_enable_latch = 1'b0, ddr = 1'b0;
  int          e, ds, j;
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = ~i[7:0];
    dev_dq = 4'h0;
    dev_oe = 4'h0;
  end
  always @(negedge cs_n)
  begin
    e = 0;
    opc = 8'h0;
    ddr = 1'b0;
    for (int i = 0; i < 256; i++)
      pmask[i] = 1'b0;
  end
  always @(posedge cs_n)
  begin
    dev_oe = 4'h0;
    if (opc == 8'h06)
      write_enable_latch = 1'b1;
    if ((opc == 8'h64 || opc == 8'h62) && write_enable_latch && !LOCK[adr[13:12]] &&
        e >= (opc == 8'h62 ? 79 : 63))
    begin
      for (int i = 0; i < 256; i++)
        if (opc == 8'h64)
          mem[{adr[13:12], i[7:0]}] = 8'hff;
        else if (pmask[i])
          mem[{adr[13:12], i[7:0]}] &= pbuf[i];
      in_progress_flag = 1'b1;
      fork
        begin
          #(BUSY_NS);
          in_progress_flag = 1'b0;
          write_enable_latch = 1'b0;
        end
      join_none
    end
  end
  always @(sck)
    if (!cs_n)
    begin
      e = e + 1;
      if (ddr ? (e > 16 && e <= 40) : e[0])
        sr = {sr[30:0], dq[0]};
      if (e == 15)
      begin
        opc = (in_progress_flag && sr[7:0] != 8'h05) ? 8'h00 : sr[7:0];
        ddr = opc == 8'h0d;
        ds = opc == 8'h05 ? 16 : (opc == 8'h68 ? 80 : 56);
      end
      if (e == (ddr ? 40 : 63))
      begin
        adr = sr[23:0];
        off = sr[7:0];
      end
      if (opc == 8'h62 && e > 63 && e[0] && ((e + 1) / 2) % 8 == 0)
      begin
        pbuf[off] = sr[7:0];
        pmask[off] = 1'b1;
        off = off + 8'h1;
      end
      if ((opc == 8'h05 || opc == 8'h68 || ddr) && e >= ds && (ddr || !e[0]))
      begin
        j = ddr ? e - ds : (e - ds) / 2;
        a = adr + 24'(j / 8);
        ob = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
        if (opc == 8'h68)
          ob = mem[{adr[13:12], adr[7:0] + j[10:3]}];
        if (opc == 8'h05)
          ob = {6'h0, write_enable_latch, in_progress_flag};
        dev_dq[1] = ob[7 - j % 8];
        dev_oe = 4'h2;
      end
    end
endmodule

// File: verif/testbench.sv
// self-checking bench of the row flash host against the flash model
module testbench
  import row_flash_host_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic err;} row_s;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, cs_n, sck, junk = 1'b0, errv;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0]  dq_in, dq_out, dq_oe, dev_dq, dev_oe;
  logic [7:0]  eq [$];
  int          error_cnt = 0, n_checks = 0;
  row_s        rows [7] = '{
    '{1'b0, REG_CFG, 32'h0, 32'h648, 1'b0}, '{1'b0, REG_LEN, 32'h0, 32'h1, 1'b0},
    '{1'b0, REG_STATUS, 32'h0, 32'h0, 1'b0}, '{1'b1, REG_LEN, 32'hffffffff, 32'h0, 1'b0},
    '{1'b0, REG_LEN, 32'h0, 32'h1ff, 1'b0}, '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h40, 32'h5, 32'h0, 1'b1}};
  always #10 pclk = ~pclk;
  always @(posedge pclk) junk <= ~junk;
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & dev_oe & dev_dq) | (~dq_oe & ~dev_oe & {4{junk}});
  row_flash_host u_row_flash_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  flash_row_model u_flash_row_model (.cs_n(cs_n), .sck(sck), .dq(dq_in), .dev_dq(dev_dq),
    .dev_oe(dev_oe));
  function automatic logic [7:0] fx(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_st(input int b, input logic v);
    do
      apb(1'b0, REG_STATUS, 32'h0);
    while (rdv[b] !== v);
  endtask
  task automatic start(input op_kind_e op, input logic [23:0] a, input int n);
    apb(1'b1, REG_ADDR, {8'h0, a});
    apb(1'b1, REG_LEN, 32'(n));
    apb(1'b1, REG_CMD, {29'h0, op});
  endtask
  task automatic rd(input op_kind_e op, input logic [23:0] a, input int n);
    start(op, a, n);
    repeat (n)
    begin
      wait_st(ST_RXFULL_BIT, 1'b1);
      apb(1'b0, REG_RXDATA, 32'h0);
      chk("rxdata", {24'h0, eq.pop_front()}, rdv);
    end
    wait_st(ST_BUSY_BIT, 1'b0);
  endtask
  task automatic prog(input logic [23:0] a, input int n);
    start(OP_ROW_PROGRAM, a, n);
    repeat (n)
    begin
      wait_st(ST_TXFULL_BIT, 1'b0);
      apb(1'b1, REG_TXDATA, {24'h0, eq.pop_front()});
    end
    wait_st(ST_BUSY_BIT, 1'b0);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("prdata", rows[i].rd, rdv);
      chk("pslverr", {31'h0, rows[i].err}, {31'h0, errv});
    end
    eq = '{8'hfa};
    rd(OP_ROW_READ, 24'h000005, 1);
    start(OP_ROW_ERASE, 24'h100, 1);
    wait_st(ST_BUSY_BIT, 1'b0);
    chk("latch", 32'h0, {31'h0, u_flash_row_model.write_enable_latch});
    eq = '{8'h3c, 8'ha5};
    prog(24'h1ff, 2);
    eq = '{8'ha5, 8'hff};
    rd(OP_ROW_READ, 24'h100, 2);
    eq = '{8'hf0};
    prog(24'h1ff, 1);
    eq = '{8'h30};
    rd(OP_ROW_READ, 24'h1ff, 1);
    eq = '{8'h00};
    prog(24'h300, 1);
    eq = '{8'hff};
    rd(OP_ROW_READ, 24'h300, 1);
    eq = '{fx(24'hfffffe), fx(24'hffffff), fx(24'h0)};
    rd(OP_SINGLE_DDR, 24'hfffffe, 3);
    start(OP_ROW_ERASE, 24'h200, 1);
    apb(1'b1, REG_CMD, {29'h0, OP_ROW_READ});
    wait_st(ST_BUSY_BIT, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("err", 32'h1, {31'h0, rdv[ST_ERR_BIT]});
    apb(1'b1, REG_STATUS, 32'h10);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("err_clr", 32'h0, {31'h0, rdv[ST_ERR_BIT]});
    eq = '{8'h00};
    rd(OP_STATUS, 24'h0, 1);
    apb(1'b1, REG_CFG, 32'h111);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_CFG, 32'h0);
    chk("cfg_rst", 32'h648, rdv);
    close_out();
  end
endmodule
